// ---- hdl/input_capture_map.vh ----
`ifndef INPUT_CAPTURE_MAP_VH
`define INPUT_CAPTURE_MAP_VH

// Register byte offsets on the AXI4-Lite slave.
`define ICM_CTRL_OFS        8'h00
`define ICM_FIFO_STAT_OFS   8'h04
`define ICM_INT_STAT_OFS    8'h08
`define ICM_INT_MASK_OFS    8'h0c
`define ICM_RESULT_OFS      8'h10

// Control register fields.
`define ICM_CTRL_MODE_LSB   0
`define ICM_CTRL_MODE_MSB   2
`define ICM_CTRL_FIRST_RISE 3
`define ICM_CTRL_CASCADE    4
`define ICM_CTRL_TSEL       5
`define ICM_CTRL_THR_LSB    6
`define ICM_CTRL_THR_MSB    7
`define ICM_CTRL_RESET      8'h00

// Capture modes.
`define ICM_MODE_OFF        3'h0
`define ICM_MODE_EVERY_EDGE 3'h1
`define ICM_MODE_DIV4       3'h2
`define ICM_MODE_DIV16      3'h3
`define ICM_MODE_RISE       3'h4
`define ICM_MODE_FALL       3'h5

// Prescaler terminal counts.
`define ICM_DIV4_LAST       4'h3
`define ICM_DIV16_LAST      4'hf

// Interrupt status and mask bits.
`define ICM_INT_CAPTURE     0
`define ICM_INT_THRESHOLD   1
`define ICM_INT_OVERFLOW    2
`define ICM_INT_WIDTH       3
`define ICM_INT_MASK_RESET  3'h0

// FIFO status fields.
`define ICM_FS_NOT_EMPTY    0
`define ICM_FS_FULL         1
`define ICM_FS_LEVEL_LSB    2

// Position of the alternate time-base select bit in the system configuration word.
`define ICM_ALT_TB_BIT      17

// AXI response codes.
`define ICM_RESP_OKAY       2'h0
`define ICM_RESP_SLVERR     2'h2

`endif

// ---- hdl/capture_fifo_mem.v ----
module capture_fifo_mem #(
  parameter DATA_W = 32,
  parameter ADDR_W = 2
) (
  input  wire              mclk,
  input  wire              wr_en,
  input  wire [ADDR_W-1:0] wr_addr,
  input  wire [DATA_W-1:0] wr_data,
  input  wire [ADDR_W-1:0] rd_addr,
  output reg  [DATA_W-1:0] rd_data_r
);

  reg [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  always @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data_r <= mem[rd_addr];
  end

endmodule // capture_fifo_mem

// ---- hdl/capture_edge_qualifier.v ----
`include "input_capture_map.vh"

module capture_edge_qualifier (
  input  wire       mclk,
  input  wire       rst,
  input  wire       pin,
  input  wire [2:0] mode,
  input  wire       first_rise,
  output reg        capture_r,
  output reg        pin_edge_r
);

  reg       pin_prev_r;
  reg       armed_r;
  reg [3:0] presc_r;
  reg [3:0] presc_nxt;
  reg       hit_nxt;

  wire rise = pin & ~pin_prev_r;
  wire fall = ~pin & pin_prev_r;
  wire on   = (mode != `ICM_MODE_OFF);

  always @*
  begin
    hit_nxt   = 1'b0;
    presc_nxt = presc_r;
    case (mode)
      `ICM_MODE_EVERY_EDGE:
        hit_nxt = armed_r ? (rise | fall) : (first_rise ? rise : fall);
      `ICM_MODE_DIV4:
      begin
        if (rise)
        begin
          hit_nxt   = (presc_r == `ICM_DIV4_LAST);
          presc_nxt = hit_nxt ? 4'h0 : presc_r + 4'h1;
        end
      end
      `ICM_MODE_DIV16:
      begin
        if (rise)
        begin
          hit_nxt   = (presc_r == `ICM_DIV16_LAST);
          presc_nxt = presc_r + 4'h1;
        end
      end
      `ICM_MODE_RISE:
        hit_nxt = rise;
      `ICM_MODE_FALL:
        hit_nxt = fall;
      default:
        hit_nxt = 1'b0;
    endcase
  end

  // The pin is sampled once so edges are seen as single-cycle pulses.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pin_prev_r <= 1'b0;
      armed_r    <= 1'b0;
      presc_r    <= 4'h0;
      capture_r  <= 1'b0;
      pin_edge_r <= 1'b0;
    end
    else
    begin
      pin_prev_r <= pin;
      // Turning the channel off restarts the prescaler and the first-edge choice.
      armed_r    <= on & (armed_r | hit_nxt);
      presc_r    <= on ? presc_nxt : 4'h0;
      capture_r  <= hit_nxt;
      pin_edge_r <= on & (rise | fall);
    end
  end

endmodule // capture_edge_qualifier

// ---- hdl/input_capture_channel.v ----
// What this block does
// - A qualifying capture pin event latches the selected time base, 16 or 32 bits wide.
// - Every-edge mode captures on both edges, the first on the polarity software chose.
// - Divide-by-four mode captures only on every fourth rising edge.
// - Divide-by-sixteen mode captures only on every sixteenth rising edge.
// - The time base is one of six 16-bit timers or two of them cascaded to 32 bits.
// - An edge on the capture pin can wake the device from Sleep and Idle.
// - Capture events raise an interrupt request.
// - Captures go into a four-entry FIFO; the interrupt fires at 1, 2, 3 or 4 entries.
// - With the alternate select bit clear, every channel uses timers 2 and 3.
// - With it set, channels 1-3 use timers 4/5, 4-6 use 2/3, 7-9 use 6/7.
//
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`include "input_capture_map.vh"

module input_capture_channel #(
  parameter CHANNEL   = 1,
  parameter TIMER_W   = 16,
  parameter NUM_TMR   = 6,
  parameter FIFO_AW   = 2,
  parameter ADDR_W    = 8
) (
  input  wire                       mclk,
  input  wire                       rst,
  input  wire                       capture_input_pin,
  input  wire [NUM_TMR*TIMER_W-1:0] timer_counts,
  input  wire [31:0]                system_config_register,
  output reg                        wake_request_r,
  output wire                       irq,
  input  wire [ADDR_W-1:0]          s_axi_awaddr,
  input  wire                       s_axi_awvalid,
  output wire                       s_axi_awready,
  input  wire [31:0]                s_axi_wdata,
  input  wire [3:0]                 s_axi_wstrb,
  input  wire                       s_axi_wvalid,
  output wire                       s_axi_wready,
  output reg  [1:0]                 s_axi_bresp,
  output reg                        s_axi_bvalid,
  input  wire                       s_axi_bready,
  input  wire [ADDR_W-1:0]          s_axi_araddr,
  input  wire                       s_axi_arvalid,
  output wire                       s_axi_arready,
  output reg  [31:0]                s_axi_rdata,
  output reg  [1:0]                 s_axi_rresp,
  output reg                        s_axi_rvalid,
  input  wire                       s_axi_rready
);

  localparam [FIFO_AW:0] DEPTH = {1'b1, {FIFO_AW{1'b0}}};

  // Index of the primary timer of the pair, counted from timer 2.
  function [2:0] pair_base;
    input integer ch;
    input         alt;
    begin
      if (!alt)
        pair_base = 3'h0;
      else if (ch <= 3)
        pair_base = 3'h2;
      else if (ch <= 6)
        pair_base = 3'h0;
      else
        pair_base = 3'h4;
    end
  endfunction

  function [TIMER_W-1:0] timer_at;
    input [NUM_TMR*TIMER_W-1:0] all;
    input [2:0]                 idx;
    begin
      timer_at = all[idx*TIMER_W +: TIMER_W];
    end
  endfunction

  reg  [7:0]              ctrl_r;
  reg  [2:0]              int_stat_r;
  reg  [2:0]              int_stat_nxt;
  reg  [2:0]              int_mask_r;
  reg  [FIFO_AW-1:0]      wr_ptr_r;
  reg  [FIFO_AW-1:0]      rd_ptr_r;
  reg  [FIFO_AW:0]        level_r;
  reg  [FIFO_AW:0]        level_nxt;
  reg  [ADDR_W-1:0]       awaddr_r;
  reg                     aw_held_r;
  reg  [31:0]             wdata_r;
  reg  [3:0]              wstrb_r;
  reg                     w_held_r;
  reg  [ADDR_W-1:0]       araddr_r;
  reg                     rd_pend_r;
  reg                     res_ok_r;
  reg  [31:0]             rdata_nxt;
  reg  [1:0]              rresp_nxt;
  reg  [31:0]             cap_value;

  wire [2:0]              mode = ctrl_r[`ICM_CTRL_MODE_MSB:`ICM_CTRL_MODE_LSB];
  wire                    on   = (mode != `ICM_MODE_OFF);
  wire                    cap_hit;
  wire                    pin_edge;
  wire [31:0]             fifo_rdata;
  wire [1:0]              thr  = ctrl_r[`ICM_CTRL_THR_MSB:`ICM_CTRL_THR_LSB];
  wire                    full = (level_r == DEPTH);

  capture_edge_qualifier u_qual (
    .mclk       (mclk),
    .rst        (rst),
    .pin        (capture_input_pin),
    .mode       (mode),
    .first_rise (ctrl_r[`ICM_CTRL_FIRST_RISE]),
    .capture_r  (cap_hit),
    .pin_edge_r (pin_edge)
  );

  // Time base selection.
  wire       alt_sel = system_config_register[`ICM_ALT_TB_BIT];
  wire [2:0] pri_idx = pair_base(CHANNEL, alt_sel);
  wire [2:0] sec_idx = pri_idx + 3'h1;
  wire [TIMER_W-1:0] pri_cnt = timer_at(timer_counts, pri_idx);
  wire [TIMER_W-1:0] sec_cnt = timer_at(timer_counts, sec_idx);

  always @*
  begin
    if (ctrl_r[`ICM_CTRL_CASCADE])
      cap_value = {sec_cnt, pri_cnt};
    else if (ctrl_r[`ICM_CTRL_TSEL])
      cap_value = {{(32-TIMER_W){1'b0}}, sec_cnt};
    else
      cap_value = {{(32-TIMER_W){1'b0}}, pri_cnt};
  end

  // A capture into a full FIFO is dropped so the unread entries survive.
  wire push = cap_hit & ~full;
  wire pop  = rd_pend_r & res_ok_r;

  // The read data are the value presented on the FIFO's registered read port.
  capture_fifo_mem #(
    .DATA_W (32),
    .ADDR_W (FIFO_AW)
  ) u_mem (
    .mclk      (mclk),
    .wr_en     (push),
    .wr_addr   (wr_ptr_r),
    .wr_data   (cap_value),
    .rd_addr   (rd_ptr_r),
    .rd_data_r (fifo_rdata)
  );

  always @*
  begin
    level_nxt = level_r;
    if (push & ~pop)
      level_nxt = level_r + 1'b1;
    else if (pop & ~push)
      level_nxt = level_r - 1'b1;
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      wr_ptr_r <= {FIFO_AW{1'b0}};
      rd_ptr_r <= {FIFO_AW{1'b0}};
      level_r  <= {(FIFO_AW+1){1'b0}};
    end
    else if (!on)
    begin
      // Switching the channel off discards whatever was left unread.
      wr_ptr_r <= {FIFO_AW{1'b0}};
      rd_ptr_r <= {FIFO_AW{1'b0}};
      level_r  <= {(FIFO_AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      level_r <= level_nxt;
    end
  end

  // Wake request follows every pin edge while the channel is on, even in sleep.
  always @(posedge mclk)
  begin
    if (rst)
      wake_request_r <= 1'b0;
    else
      wake_request_r <= pin_edge;
  end

  // Interrupt status.
  wire stat_rd = rd_pend_r && (araddr_r == `ICM_INT_STAT_OFS);
  wire [2:0] ev;
  assign ev[`ICM_INT_CAPTURE]   = cap_hit;
  assign ev[`ICM_INT_THRESHOLD] = on && (level_r > {1'b0, thr});
  assign ev[`ICM_INT_OVERFLOW]  = cap_hit & full;

  always @*
  begin
    // A new event in the clearing read's cycle survives the clear.
    int_stat_nxt = (stat_rd ? 3'h0 : int_stat_r) | ev;
  end

  always @(posedge mclk)
  begin
    if (rst)
      int_stat_r <= 3'h0;
    else
      int_stat_r <= int_stat_nxt;
  end

  assign irq = |(int_stat_r & int_mask_r);

  // AXI4-Lite write path: address and data are taken independently.
  assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;

  wire do_write = aw_held_r & w_held_r;
  wire wr_map   = (awaddr_r == `ICM_CTRL_OFS) || (awaddr_r == `ICM_INT_MASK_OFS) ||
                  (awaddr_r == `ICM_FIFO_STAT_OFS) || (awaddr_r == `ICM_INT_STAT_OFS) ||
                  (awaddr_r == `ICM_RESULT_OFS);

  always @(posedge mclk)
  begin
    if (rst)
    begin
      aw_held_r    <= 1'b0;
      w_held_r     <= 1'b0;
      awaddr_r     <= {ADDR_W{1'b0}};
      wdata_r      <= 32'h0;
      wstrb_r      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `ICM_RESP_OKAY;
      ctrl_r       <= `ICM_CTRL_RESET;
      int_mask_r   <= `ICM_INT_MASK_RESET;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `ICM_RESP_OKAY : `ICM_RESP_SLVERR;
        if (wstrb_r[0] && awaddr_r == `ICM_CTRL_OFS)
          ctrl_r <= wdata_r[7:0];
        if (wstrb_r[0] && awaddr_r == `ICM_INT_MASK_OFS)
          int_mask_r <= wdata_r[`ICM_INT_WIDTH-1:0];
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path: two cycles so the FIFO read port has settled.
  assign s_axi_arready = ~rd_pend_r & ~s_axi_rvalid;

  always @*
  begin
    rresp_nxt = `ICM_RESP_OKAY;
    case (araddr_r)
      `ICM_CTRL_OFS:
        rdata_nxt = {24'h0, ctrl_r};
      `ICM_FIFO_STAT_OFS:
        rdata_nxt = {{(32-FIFO_AW-3){1'b0}}, level_r, full, (level_r != 0)};
      `ICM_INT_STAT_OFS:
        rdata_nxt = {29'h0, int_stat_r};
      `ICM_INT_MASK_OFS:
        rdata_nxt = {29'h0, int_mask_r};
      `ICM_RESULT_OFS:
        // An empty FIFO reads as zero and is left untouched.
        rdata_nxt = res_ok_r ? fifo_rdata : 32'h0;
      default:
      begin
        rdata_nxt = 32'h0;
        rresp_nxt = `ICM_RESP_SLVERR;
      end
    endcase
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      rd_pend_r    <= 1'b0;
      res_ok_r     <= 1'b0;
      araddr_r     <= {ADDR_W{1'b0}};
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= `ICM_RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rd_pend_r <= 1'b1;
        araddr_r  <= s_axi_araddr;
        // Emptiness is judged at acceptance, matching the data the read port holds.
        res_ok_r  <= (s_axi_araddr == `ICM_RESULT_OFS) && (level_r != 0) && on;
      end
      else if (rd_pend_r)
      begin
        rd_pend_r    <= 1'b0;
        res_ok_r     <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdata_nxt;
        s_axi_rresp  <= rresp_nxt;
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // input_capture_channel

// ---- testbench/capture_properties.sv ----
`include "input_capture_map.vh"

module capture_properties #(
  parameter ADDR_W = 8
) (
  input wire logic              mclk,
  input wire logic              rst,
  input wire logic              capture_input_pin,
  input wire logic              wake_request_r,
  input wire logic              irq,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read response dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during answer");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during answer");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    !s_axi_rvalid ##1 s_axi_rvalid) else $error("read answer late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr > 8'h10 |-> ##2 s_axi_rresp == `ICM_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Allows for an input synchroniser of up to one stage ahead of the edge detector.
  a_wake_edge: assert property (wake_request_r |->
    $past(capture_input_pin, 1) != $past(capture_input_pin, 2) ||
    $past(capture_input_pin, 2) != $past(capture_input_pin, 3) ||
    $past(capture_input_pin, 3) != $past(capture_input_pin, 4))
    else $error("wake without pin edge");

  c_irq: cover property ($rose(irq));
  c_wake: cover property (wake_request_r);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `ICM_RESP_SLVERR);
endmodule // capture_properties

// ---- testbench/pin_source.sv ----
module pin_source (
  input wire logic mclk,
  output logic     pin
);
  timeunit 1ns;
  timeprecision 1ps;
  initial pin = 1'b0;
  // Each pulse is a rise then a fall, three cycles apart, so every edge is seen.
  task automatic pulses(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      pin <= 1'b1;
      repeat (3) @(posedge mclk);
      pin <= 1'b0;
      repeat (3) @(posedge mclk);
    end
  endtask
endmodule // pin_source

// ---- testbench/tb.sv ----
`include "input_capture_map.vh"

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CH = 8;
  logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [95:0] tc;
  logic [31:0] cfg, wdata, v;
  logic [31:0] vals [4];
  logic [7:0]  awaddr, araddr;
  logic [1:0]  r;
  wire         pin, awready, wready, bvalid, arready, rvalid, irq, wake;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rd;
  int          err_count, samples_checked, wake_cnt, w0;
  // The last entry uses a spare mode code: the channel stays on but never captures.
  logic [3:0]  md [9] = '{4'h9, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4, 4'h5, 4'h6};
  int          np [9] = '{1, 1, 3, 4, 15, 16, 3, 2, 1};
  logic [2:0]  lv [9] = '{3'h2, 3'h1, 3'h0, 3'h1, 3'h0, 3'h1, 3'h3, 3'h2, 3'h0};

  pin_source i_pin_source (.mclk(mclk), .pin(pin));
  input_capture_channel #(.CHANNEL(CH)) i_input_capture_channel (
    .mclk(mclk), .rst(rst), .capture_input_pin(pin), .timer_counts(tc),
    .system_config_register(cfg), .wake_request_r(wake), .irq(irq),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  always @(posedge mclk) if (wake === 1'b1) wake_cnt <= wake_cnt + 1;

  task report_and_stop();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // Address and data go out together; each is released only at the edge that takes it.
  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
    bit ad, wd;
    ad = 0;
    wd = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge mclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    d = rd;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task wreg(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, r);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a, v, r);
    chk(v, e);
  endtask

  function automatic logic [31:0] expc(input logic alt, casc, ts, input logic [95:0] t);
    int b;
    logic [15:0] p, s;
    b = (!alt || (CH > 3 && CH < 7)) ? 0 : (CH < 4 ? 2 : 4);
    p = t[16*b +: 16];
    s = t[16*b+16 +: 16];
    return casc ? {s, p} : {16'h0, ts ? s : p};
  endfunction

  initial
  begin
    repeat (30000) @(posedge mclk);
    err_count++;
    report_and_stop();
  end

  initial
  begin
    {rst, awvalid, wvalid, bready, arvalid, rready} = 6'h20;
    {tc, cfg, wdata, awaddr, araddr} = '0;
    void'($urandom(32'hebcbb7d3));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rchk(`ICM_CTRL_OFS, 32'h0);
    rchk(`ICM_INT_MASK_OFS, 32'h0);
    rchk(`ICM_FIFO_STAT_OFS, 32'h0);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      tc <= {$urandom, $urandom, $urandom};
      cfg <= ($urandom & 32'hfffdffff) | (32'(i[0]) << 17);
      wreg(`ICM_CTRL_OFS, {26'h0, i[2], i[1], 1'b0, `ICM_MODE_RISE});
      i_pin_source.pulses(1);
      repeat (4) @(posedge mclk);
      rchk(`ICM_RESULT_OFS, expc(cfg[17], i[1], i[2], tc));
      wreg(`ICM_CTRL_OFS, 32'h0);
    end
    for (int k = 0; k < 9; k++)
    begin
      w0 = wake_cnt;
      wreg(`ICM_CTRL_OFS, {28'h0, md[k]});
      i_pin_source.pulses(np[k]);
      repeat (4) @(posedge mclk);
      rchk(`ICM_FIFO_STAT_OFS, {27'h0, lv[k], 1'b0, lv[k] != 3'h0});
      chk(wake_cnt - w0, 2 * np[k]);
      wreg(`ICM_CTRL_OFS, 32'h0);
    end
    wreg(`ICM_INT_MASK_OFS, 32'h2);
    for (int t = 0; t < 4; t++)
    begin
      rdr(`ICM_INT_STAT_OFS, v, r);
      wreg(`ICM_CTRL_OFS, {24'h0, t[1:0], 3'h0, `ICM_MODE_RISE});
      i_pin_source.pulses(t);
      repeat (4) @(posedge mclk);
      chk(irq, 32'h0);
      i_pin_source.pulses(1);
      repeat (4) @(posedge mclk);
      chk(irq, 32'h1);
      wreg(`ICM_CTRL_OFS, 32'h0);
    end
    wreg(`ICM_INT_MASK_OFS, 32'h7);
    wreg(`ICM_CTRL_OFS, {24'h0, 2'h3, 3'h0, `ICM_MODE_RISE});
    rdr(`ICM_INT_STAT_OFS, v, r);
    chk(irq, 32'h0);
    for (int j = 0; j < 5; j++)
    begin
      @(posedge mclk);
      tc <= {$urandom, $urandom, $urandom};
      i_pin_source.pulses(1);
      if (j < 4) vals[j] = expc(cfg[17], 1'b0, 1'b0, tc);
    end
    repeat (4) @(posedge mclk);
    chk(irq, 32'h1);
    rchk(`ICM_FIFO_STAT_OFS, 32'h13);
    rchk(`ICM_INT_STAT_OFS, 32'h7);
    for (int j = 0; j < 4; j++) rchk(`ICM_RESULT_OFS, vals[j]);
    rchk(`ICM_RESULT_OFS, 32'h0);
    rdr(`ICM_INT_STAT_OFS, v, r);
    repeat (2) @(posedge mclk);
    chk(irq, 32'h0);
    wr(8'h20, $urandom, r);
    chk(r, `ICM_RESP_SLVERR);
    rchk(8'h20, 32'h0);
    chk(r, `ICM_RESP_SLVERR);
    report_and_stop();
  end
endmodule // tb

bind input_capture_channel capture_properties #(.ADDR_W(ADDR_W)) i_capture_properties (
  .mclk(mclk), .rst(rst), .capture_input_pin(capture_input_pin),
  .wake_request_r(wake_request_r), .irq(irq), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
